//--- core/twmr_consts.svh
// Purpose: timing counts and field positions of the two-wire master
// Assumes: system clock period of 25 ns
// Notes:   quarter-bit time gives a 100 kbit/s serial clock
`ifndef TWMR_CONSTS_SVH
`define TWMR_CONSTS_SVH
`define TWMR_CLK_NS 25
`define TWMR_QTR_NS 2500
`define TWMR_QTR_CYC ((`TWMR_QTR_NS + `TWMR_CLK_NS - 1) / `TWMR_CLK_NS)
`define TWMR_DIV_W 8
`define TWMR_LAST_BIT 4'h8
`define TWMR_BIT7 4'h7
`define TWMR_PH_LAST 2'h3
`define TWMR_PH_SAMPLE 2'h2
`endif

//--- core/twmr_master.sv
// Purpose: master read/write sequencer of a two-wire serial controller
// Assumes: open-drain pins, output value 0, enable low while driving
// Notes:   target clock stretching is not observed
`include "twmr_consts.svh"
`default_nettype none
// Behaviour
// - start command sends start then address
// - read direction bit sent as one
// - release data on ninth pulse
// - high ack sets no-ack flag
// - ack received bytes, not the last
// - rx full set on store, cleared on read
// - rx full paces dma receive
// - tx empty paces dma transmit
// - internal address write, then repeated start
// - up to three internal address bytes
// - upper internal bytes usable in ten-bit
// - quick trigger starts quick frame
// - eight bits msb first plus ack
// - start/stop are data edges, clock high
module twmr_master
  import twmr_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        MASTER_EN,
  input  wire logic        START_CMD,
  input  wire logic        STOP_CMD,
  input  wire logic        QUICK_CMD,
  input  wire logic        READ_DIRECTION,
  input  wire logic [6:0]  TARGET_ADDR_FIELD,
  input  wire logic [1:0]  INTERNAL_ADDR_SIZE,
  input  wire logic [23:0] INTERNAL_ADDR_BYTES,
  input  wire logic [7:0]  TX_DATA,
  input  wire logic        TX_WRITE,
  input  wire logic        RX_READ,
  input  wire logic        STATUS_READ,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OEN,
  output logic             SCL_OUT,
  output logic             SCL_OEN,
  output logic [7:0]       RX_HOLDING_REG,
  output logic             RX_HOLDING_FULL,
  output logic             TX_HOLDING_EMPTY,
  output logic             RX_DMA_REQ,
  output logic             TX_DMA_REQ,
  output logic             NO_ACK_FLAG,
  output logic             TX_COMPLETE,
  output logic             BUSY
);
  twmr_state_t state;
  twmr_state_t next_be_state;
  twmr_kind_t  kind;
  twmr_kind_t  next_be_kind;
  twmr_cfg_t   cfg;
  logic [1:0]  phase;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  tx_hold;
  logic [1:0]  ia_left;
  logic        stop_pend;
  logic        ack_bad;
  logic        rx_last;
  logic        rd_phase2;
  logic        sda_m;
  logic        sda_s;
  logic        tick;
  logic        go;
  logic        first_dir;
  logic        byte_end;
  logic        be_load_ia;
  logic        be_load_tx;
  logic        tx_load;
  logic        rx_store;
  logic        no_ack_flag_event;
  logic        next_scl_rel;
  logic        next_sda_rel;
  logic [7:0]  ia_byte;

  twmr_tick u_tick (
    .clk  (CLK_SYS),
    .rst  (RST),
    .run  (state != ST_IDLE),
    .tick (tick)
  );

  // data pin synchroniser
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end
    else
    begin
      sda_m <= SDA_IN;
      sda_s <= sda_m;
    end
  end

  assign go = MASTER_EN && (START_CMD || QUICK_CMD || (TX_WRITE && !READ_DIRECTION));
  // with internal address the first phase writes; quick sends the command bit
  assign first_dir = QUICK_CMD ? READ_DIRECTION
                   : (READ_DIRECTION && INTERNAL_ADDR_SIZE == 2'h0);
  assign byte_end = tick && state == ST_BIT && phase == `TWMR_PH_LAST
                    && bit_cnt == `TWMR_LAST_BIT;
  assign rx_store = byte_end && kind == K_RDATA;
  assign no_ack_flag_event = byte_end && kind != K_RDATA && ack_bad;
  assign tx_load = (byte_end && be_load_tx)
                   || (tick && state == ST_WAIT && !TX_HOLDING_EMPTY);

  // internal address bytes go most significant first; ten-bit uses the low byte
  always_comb
  begin
    case (ia_left)
      2'h3:    ia_byte = cfg.iaddr[23:16];
      2'h2:    ia_byte = cfg.iaddr[15:8];
      default: ia_byte = cfg.iaddr[7:0];
    endcase
  end

  // what follows the byte now ending
  always_comb
  begin
    next_be_state = ST_STOP;
    next_be_kind = kind;
    be_load_ia = 1'b0;
    be_load_tx = 1'b0;
    if (kind == K_RDATA)
    begin
      if (!rx_last)
        next_be_state = ST_BIT;
    end
    else if (ack_bad || cfg.quick)
      next_be_state = ST_STOP;
    else if (kind == K_ADDR && rd_phase2)
    begin
      next_be_state = ST_BIT;
      next_be_kind = K_RDATA;
    end
    else if (kind != K_WDATA && ia_left != 2'h0)
    begin
      next_be_state = ST_BIT;
      next_be_kind = K_IADDR;
      be_load_ia = 1'b1;
    end
    else if (cfg.rd && kind == K_IADDR)
      next_be_state = ST_RSTART;
    else if (cfg.rd)
    begin
      next_be_state = ST_BIT;
      next_be_kind = K_RDATA;
    end
    else if (!TX_HOLDING_EMPTY)
    begin
      next_be_state = ST_BIT;
      next_be_kind = K_WDATA;
      be_load_tx = 1'b1;
    end
    else if (!stop_pend)
      next_be_state = ST_WAIT;
  end

  // sequencer
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      state <= ST_IDLE;
      kind <= K_ADDR;
      cfg <= '0;
      phase <= 2'h0;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ia_left <= 2'h0;
      stop_pend <= 1'b0;
      ack_bad <= 1'b0;
      rx_last <= 1'b0;
      rd_phase2 <= 1'b0;
    end
    else
    begin
      if (STOP_CMD && state != ST_IDLE)
        stop_pend <= 1'b1;
      case (state)
        ST_IDLE:
          if (go)
          begin
            state <= ST_START;
            kind <= K_ADDR;
            cfg <= '{READ_DIRECTION, QUICK_CMD, INTERNAL_ADDR_SIZE,
                     TARGET_ADDR_FIELD, INTERNAL_ADDR_BYTES};
            ia_left <= QUICK_CMD ? 2'h0 : INTERNAL_ADDR_SIZE;
            shreg <= {TARGET_ADDR_FIELD, first_dir};
            phase <= 2'h0;
            stop_pend <= STOP_CMD;
            ack_bad <= 1'b0;
            rd_phase2 <= 1'b0;
          end
        ST_START, ST_RSTART, ST_STOP:
          if (tick)
          begin
            phase <= phase + 2'h1;
            bit_cnt <= 4'h0;
            if (phase == `TWMR_PH_LAST)
            begin
              if (state == ST_STOP)
                state <= ST_IDLE;
              else
                state <= ST_BIT;
              if (state == ST_RSTART)
              begin
                kind <= K_ADDR;
                shreg <= {cfg.addr, 1'b1};
                rd_phase2 <= 1'b1;
              end
            end
          end
        ST_BIT:
          if (tick)
          begin
            phase <= phase + 2'h1;
            if (phase == `TWMR_PH_SAMPLE && bit_cnt != `TWMR_LAST_BIT && kind == K_RDATA)
              shreg <= {shreg[6:0], sda_s};
            if (phase == `TWMR_PH_SAMPLE && bit_cnt == `TWMR_LAST_BIT && kind != K_RDATA)
              ack_bad <= sda_s;
            if (phase == `TWMR_PH_LAST && bit_cnt != `TWMR_LAST_BIT)
            begin
              bit_cnt <= bit_cnt + 4'h1;
              if (kind != K_RDATA)
                shreg <= {shreg[6:0], 1'b0};
              if (bit_cnt == `TWMR_BIT7)
                rx_last <= stop_pend;
            end
            if (byte_end)
            begin
              bit_cnt <= 4'h0;
              state <= next_be_state;
              kind <= next_be_kind;
              if (be_load_ia)
              begin
                shreg <= ia_byte;
                ia_left <= ia_left - 2'h1;
              end
              if (be_load_tx)
                shreg <= tx_hold;
            end
          end
        ST_WAIT:
          if (tick)
          begin
            phase <= 2'h0;
            bit_cnt <= 4'h0;
            if (!TX_HOLDING_EMPTY)
            begin
              state <= ST_BIT;
              kind <= K_WDATA;
              shreg <= tx_hold;
            end
            else if (stop_pend)
              state <= ST_STOP;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // pin levels per state and quarter-bit phase
  always_comb
  begin
    next_scl_rel = 1'b1;
    next_sda_rel = 1'b1;
    case (state)
      ST_START:
      begin
        next_sda_rel = (phase == 2'h0);
        next_scl_rel = (phase < 2'h2);
      end
      ST_RSTART:
      begin
        next_sda_rel = (phase < 2'h2);
        next_scl_rel = (phase == 2'h1 || phase == 2'h2);
      end
      ST_STOP:
      begin
        next_sda_rel = (phase >= 2'h2);
        next_scl_rel = (phase != 2'h0);
      end
      ST_BIT:
      begin
        next_scl_rel = (phase == 2'h1 || phase == 2'h2);
        if (bit_cnt == `TWMR_LAST_BIT)
          next_sda_rel = (kind == K_RDATA) ? rx_last : 1'b1;
        else
          next_sda_rel = (kind == K_RDATA) ? 1'b1 : shreg[7];
      end
      ST_WAIT:
        next_scl_rel = 1'b0;
      default:
      begin
        next_scl_rel = 1'b1;
        next_sda_rel = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      SCL_OEN <= 1'b1;
      SDA_OEN <= 1'b1;
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
      BUSY <= 1'b0;
    end
    else
    begin
      SCL_OEN <= next_scl_rel;
      SDA_OEN <= next_sda_rel;
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
      BUSY <= (state != ST_IDLE);
    end
  end

  // status flags and holding registers; hardware set wins over clear
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      RX_HOLDING_REG <= 8'h00;
      RX_HOLDING_FULL <= 1'b0;
      RX_DMA_REQ <= 1'b0;
      TX_HOLDING_EMPTY <= 1'b1;
      TX_DMA_REQ <= 1'b1;
      tx_hold <= 8'h00;
      NO_ACK_FLAG <= 1'b0;
      TX_COMPLETE <= 1'b1;
    end
    else
    begin
      if (rx_store)
        RX_HOLDING_REG <= shreg;
      RX_HOLDING_FULL <= rx_store || (RX_HOLDING_FULL && !RX_READ);
      RX_DMA_REQ <= rx_store || (RX_HOLDING_FULL && !RX_READ);
      if (TX_WRITE)
        tx_hold <= TX_DATA;
      TX_HOLDING_EMPTY <= tx_load || (TX_HOLDING_EMPTY && !TX_WRITE);
      TX_DMA_REQ <= tx_load || (TX_HOLDING_EMPTY && !TX_WRITE);
      NO_ACK_FLAG <= no_ack_flag_event || (NO_ACK_FLAG && !STATUS_READ);
      if (state == ST_STOP && tick && phase == `TWMR_PH_LAST)
        TX_COMPLETE <= 1'b1;
      else if (state == ST_IDLE && go)
        TX_COMPLETE <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  property p_start_go;
    (state == ST_IDLE && go) |=> state == ST_START ##1 (!SDA_OEN || state == ST_START);
  endproperty
  a_start_go: assert property (p_start_go) else $error("start not entered");

  property p_read_dir;
    (state == ST_RSTART && tick && phase == `TWMR_PH_LAST) |=> (shreg[0] && kind == K_ADDR);
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("read direction bit not one");

  property p_ack_release;
    (state == ST_BIT && kind != K_RDATA && bit_cnt == `TWMR_LAST_BIT && tick)
      |=> SDA_OEN;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("data held in ack slot");

  property p_no_ack_flag_flag;
    no_ack_flag_event |=> NO_ACK_FLAG;
  endproperty
  a_no_ack_flag_flag: assert property (p_no_ack_flag_flag) else $error("no-ack flag missed");

  property p_rx_ack;
    (state == ST_BIT && kind == K_RDATA && bit_cnt == `TWMR_LAST_BIT && !rx_last
     && phase == 2'h1) |=> !SDA_OEN;
  endproperty
  a_rx_ack: assert property (p_rx_ack) else $error("received byte not acknowledged");

  property p_rx_full;
    rx_store |=> (RX_HOLDING_FULL && RX_HOLDING_REG == $past(shreg));
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("rx holding not filled");

  property p_rx_clear;
    (RX_READ && !rx_store) |=> !RX_HOLDING_FULL;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx full not cleared");

  property p_dma_req;
    (RX_DMA_REQ == RX_HOLDING_FULL) && (TX_DMA_REQ == TX_HOLDING_EMPTY);
  endproperty
  a_dma_req: assert property (p_dma_req) else $error("dma request differs from flag");

  property p_start_edge;
    (SCL_OEN && $past(SCL_OEN) && $fell(SDA_OEN))
      |-> ($past(state) == ST_START || $past(state) == ST_RSTART);
  endproperty
  a_start_edge: assert property (p_start_edge) else $error("data fell with clock high");

  property p_stop_edge;
    (SCL_OEN && $past(SCL_OEN) && $rose(SDA_OEN)) |-> $past(state) == ST_STOP;
  endproperty
  a_stop_edge: assert property (p_stop_edge) else $error("data rose with clock high");

  property p_bit_range;
    bit_cnt <= `TWMR_LAST_BIT;
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("bit counter past ack slot");

  property p_quick_stop;
    (byte_end && cfg.quick) |=> state == ST_STOP;
  endproperty
  a_quick_stop: assert property (p_quick_stop) else $error("quick frame carried data");

  property p_ia_rstart;
    (byte_end && kind == K_IADDR && ia_left == 2'h0 && cfg.rd && !ack_bad)
      |=> state == ST_RSTART;
  endproperty
  a_ia_rstart: assert property (p_ia_rstart) else $error("no repeated start");

  c_read_done: cover property (rx_store ##[1:1000] TX_COMPLETE);
  c_quick: cover property (byte_end && cfg.quick);
  c_no_ack_flag: cover property (no_ack_flag_event);
  c_rstart: cover property (state == ST_RSTART);
endmodule : twmr_master
`default_nettype wire

//--- core/twmr_pkg.sv
// Purpose: types of the two-wire master
// Assumes: nothing
// Notes:   constants live in twmr_consts.svh
`default_nettype none
package twmr_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_START  = 3'h1,
    ST_BIT    = 3'h2,
    ST_WAIT   = 3'h3,
    ST_RSTART = 3'h4,
    ST_STOP   = 3'h5
  } twmr_state_t;
  typedef enum logic [1:0] {
    K_ADDR  = 2'h0,
    K_IADDR = 2'h1,
    K_WDATA = 2'h2,
    K_RDATA = 2'h3
  } twmr_kind_t;
  typedef struct packed {
    logic        rd;
    logic        quick;
    logic [1:0]  iasz;
    logic [6:0]  addr;
    logic [23:0] iaddr;
  } twmr_cfg_t;
endpackage : twmr_pkg
`default_nettype wire

//--- core/twmr_tick.sv
// Purpose: quarter-bit tick for the serial clock
// Assumes: run is low while the bus is idle
// Notes:   restarts from zero whenever run drops
`include "twmr_consts.svh"
`default_nettype none
module twmr_tick
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      tick
);
  logic [`TWMR_DIV_W-1:0] cnt;
  localparam logic [`TWMR_DIV_W-1:0] QTR_TOP = `TWMR_DIV_W'(`TWMR_QTR_CYC - 1);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end
    else
    begin
      tick <= run && (cnt == QTR_TOP);
      if (!run || cnt == QTR_TOP)
        cnt <= 8'h00;
      else
        cnt <= cnt + 8'h01;
    end
  end
endmodule : twmr_tick
`default_nettype wire

//--- tb/test_two_wire_master_receive_addressing.sv
// Purpose: self-checking bench of the two-wire master receiver
// Assumes: quarter-bit of 100 system cycles
// Notes:   one write frame exercises the transmit holding path
`default_nettype none
module test_two_wire_master_receive_addressing
  import twmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        CLK_SYS;
  logic        RST;
  logic        MASTER_EN;
  logic        START_CMD;
  logic        STOP_CMD;
  logic        QUICK_CMD;
  logic        READ_DIRECTION;
  logic [6:0]  TARGET_ADDR_FIELD;
  logic [1:0]  INTERNAL_ADDR_SIZE;
  logic [23:0] INTERNAL_ADDR_BYTES;
  logic        RX_READ;
  logic        TX_WRITE;
  logic [7:0]  TX_DATA;
  logic        STATUS_READ;
  logic        SDA_OUT, SDA_OEN, SCL_OUT, SCL_OEN;
  logic [7:0]  RX_HOLDING_REG;
  logic        RX_HOLDING_FULL, TX_HOLDING_EMPTY, RX_DMA_REQ, TX_DMA_REQ;
  logic        NO_ACK_FLAG, TX_COMPLETE, BUSY;
  logic        tgt_oen;
  logic [6:0]  tgt_addr;
  logic [7:0]  rd_base, adr_byte, wr_last, seed;
  int          n_start, n_stop, num_errors, n_checks;
  wire         scl = SCL_OEN;
  wire         sda = SDA_OEN & tgt_oen;
  twmr_master u_twmr_master (.CLK_SYS(CLK_SYS), .RST(RST), .MASTER_EN(MASTER_EN),
    .START_CMD(START_CMD), .STOP_CMD(STOP_CMD), .QUICK_CMD(QUICK_CMD),
    .READ_DIRECTION(READ_DIRECTION), .TARGET_ADDR_FIELD(TARGET_ADDR_FIELD),
    .INTERNAL_ADDR_SIZE(INTERNAL_ADDR_SIZE), .INTERNAL_ADDR_BYTES(INTERNAL_ADDR_BYTES),
    .TX_DATA(TX_DATA), .TX_WRITE(TX_WRITE), .RX_READ(RX_READ), .STATUS_READ(STATUS_READ),
    .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OEN(SDA_OEN), .SCL_OUT(SCL_OUT),
    .SCL_OEN(SCL_OEN), .RX_HOLDING_REG(RX_HOLDING_REG), .RX_HOLDING_FULL(RX_HOLDING_FULL),
    .TX_HOLDING_EMPTY(TX_HOLDING_EMPTY), .RX_DMA_REQ(RX_DMA_REQ), .TX_DMA_REQ(TX_DMA_REQ),
    .NO_ACK_FLAG(NO_ACK_FLAG), .TX_COMPLETE(TX_COMPLETE), .BUSY(BUSY));
  twmr_target_model u_twmr_target_model (.scl(scl), .sda(sda), .my_addr(tgt_addr),
    .rd_base(rd_base), .sda_oen(tgt_oen), .adr_byte(adr_byte), .wr_last(wr_last),
    .n_start(n_start), .n_stop(n_stop));
  initial
  begin
    CLK_SYS = 1'b0;
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end
  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction : rnd
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // entered and left just after a clock edge; one idle edge follows each pulse
  task automatic cmd(input logic [5:0] v);
    {TX_WRITE, START_CMD, STOP_CMD, QUICK_CMD, RX_READ, STATUS_READ} = v;
    @(posedge CLK_SYS);
    #2;
    {TX_WRITE, START_CMD, STOP_CMD, QUICK_CMD, RX_READ, STATUS_READ} = 6'h00;
    @(posedge CLK_SYS);
    #2;
  endtask : cmd
  task automatic wait_for(input bit full);
    int k;
    k = 0;
    while (k < 40000 && (full ? RX_HOLDING_FULL !== 1'b1 : TX_COMPLETE !== 1'b1))
    begin
      @(posedge CLK_SYS);
      #2;
      k++;
    end
    if (k == 40000)
    begin
      num_errors++;
      $display("Error wait expected done seen timeout");
      print_verdict();
    end
  endtask : wait_for
  task automatic rd_xfer(input logic [6:0] a, input logic [1:0] sz, input int n);
    int s0;
    logic [23:0] ia;
    ia = {rnd(), rnd(), rnd()};
    rd_base = rnd();
    tgt_addr = a;
    TARGET_ADDR_FIELD = a;
    INTERNAL_ADDR_SIZE = sz;
    INTERNAL_ADDR_BYTES = ia;
    READ_DIRECTION = 1'b1;
    s0 = n_start;
    cmd({2'b01, n == 1, 3'h0});
    for (int i = 0; i < n; i++)
    begin
      wait_for(1);
      check("rx_dma_req", RX_DMA_REQ, 8'h01);
      check("rx_byte", RX_HOLDING_REG, rd_base + 8'(i));
      cmd({2'b00, i == n - 2, 1'b0, 1'b1, 1'b0});
      check("rx_full", RX_HOLDING_FULL, 8'h00);
    end
    wait_for(0);
    check("starts", 8'(n_start - s0), (sz == 2'h0) ? 8'h01 : 8'h02);
    check("addr_byte", adr_byte, {a, 1'b1});
    if (sz != 2'h0)
      check("iaddr_last", wr_last, ia[7:0]);
    check("no_ack", NO_ACK_FLAG, 8'h00);
    $display("test read size %0d bytes %0d done", sz, n);
  endtask : rd_xfer
  task automatic quick(input logic [6:0] a, input logic b);
    int p0;
    tgt_addr = b ? ~a : a;
    TARGET_ADDR_FIELD = a;
    READ_DIRECTION = b;
    p0 = n_stop;
    cmd(6'h04);
    repeat (3) @(posedge CLK_SYS);
    #2;
    check("quick_busy", BUSY, 8'h01);
    check("quick_done", TX_COMPLETE, 8'h00);
    wait_for(0);
    check("quick_addr", adr_byte, {a, b});
    check("quick_stops", 8'(n_stop - p0), 8'h01);
    check("quick_no_ack_flag", NO_ACK_FLAG, {7'h00, b});
    cmd(6'h01);
    check("no_ack_flag_clear", NO_ACK_FLAG, 8'h00);
    check("idle_busy", BUSY, 8'h00);
    $display("test quick bit %0d done", b);
  endtask : quick
  task automatic wr_xfer(input logic [6:0] a, input logic [7:0] d);
    tgt_addr = a;
    TARGET_ADDR_FIELD = a;
    INTERNAL_ADDR_SIZE = 2'h0;
    READ_DIRECTION = 1'b0;
    TX_DATA = d;
    cmd(6'h28);
    check("tx_empty_busy", TX_HOLDING_EMPTY, 8'h00);
    check("tx_dma_busy", TX_DMA_REQ, 8'h00);
    check("wr_busy", BUSY, 8'h01);
    wait_for(0);
    check("wr_addr", adr_byte, {a, 1'b0});
    check("wr_data", wr_last, d);
    check("tx_empty_done", TX_HOLDING_EMPTY, 8'h01);
    check("tx_dma_done", TX_DMA_REQ, 8'h01);
    check("wr_no_ack", NO_ACK_FLAG, 8'h00);
    $display("test write done");
  endtask : wr_xfer
  initial
  begin
    logic [7:0] a;
    {TX_WRITE, START_CMD, STOP_CMD, QUICK_CMD, RX_READ, STATUS_READ} = 6'h00;
    {READ_DIRECTION, TARGET_ADDR_FIELD, INTERNAL_ADDR_SIZE} = 10'h000;
    TX_DATA = 8'h00;
    INTERNAL_ADDR_BYTES = 24'h000000;
    RST = 1'b1;
    MASTER_EN = 1'b1;
    tgt_addr = 7'h00;
    rd_base = 8'h00;
    num_errors = 0;
    n_checks = 0;
    seed = 8'h3B;
    repeat (2) @(posedge CLK_SYS);
    #2;
    RST = 1'b0;
    check("tx_empty", TX_HOLDING_EMPTY, 8'h01);
    check("tx_dma_req", TX_DMA_REQ, 8'h01);
    check("pin_values", {6'h00, SDA_OUT, SCL_OUT}, 8'h00);
    check("pins_released", {6'h00, SDA_OEN, SCL_OEN}, 8'h03);
    check("idle_flags", {6'h00, TX_COMPLETE, BUSY}, 8'h02);
    check("rx_full", RX_HOLDING_FULL, 8'h00);
    $display("test reset done");
    a = rnd();
    quick(a[6:0], 1'b0);
    quick(a[6:0], 1'b1);
    wr_xfer(a[6:0], rnd());
    rd_xfer(a[6:0], 2'h0, 1);
    a = rnd();
    rd_xfer({5'h1E, a[1:0]}, 2'h1, 2);
    rd_xfer(a[6:0], 2'h2, 2);
    rd_xfer(a[6:0], 2'h3, 1);
    print_verdict();
  end
endmodule : test_two_wire_master_receive_addressing
`default_nettype wire

//--- tb/twmr_target_model.sv
// Purpose: behavioural two-wire target for the master bench
// Assumes: open-drain lines with pull-ups, released level is high
// Notes:   read bytes are base plus their index within the frame
`default_nettype none
module twmr_target_model
(
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [6:0] my_addr,
  input  wire logic [7:0] rd_base,
  output logic            sda_oen,
  output logic [7:0]      adr_byte,
  output logic [7:0]      wr_last,
  output int              n_start,
  output int              n_stop
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh;
  logic [7:0] idx;
  logic [7:0] dat;
  int         bitn;
  logic       act;
  logic       aph;
  logic       rd;
  initial
  begin
    sda_oen = 1'b1;
    act = 1'b0;
    n_start = 0;
    n_stop = 0;
  end
  // start or repeated start restarts the address phase
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      n_start = n_start + 1;
      act = 1'b1;
      aph = 1'b1;
      rd = 1'b0;
      bitn = 0;
      idx = 8'h00;
    end
  always @(posedge sda)
    if (scl === 1'b1)
    begin
      n_stop = n_stop + 1;
      act = 1'b0;
      sda_oen = 1'b1;
    end
  // master no-ack on a read byte ends our driving
  always @(posedge scl)
    if (act)
    begin
      if (bitn < 8)
        sh = {sh[6:0], sda};
      else if (rd && !aph && sda)
        act = 1'b0;
      bitn = bitn + 1;
    end
  always @(negedge scl)
    if (act)
    begin
      if (bitn == 8)
      begin
        if (aph)
        begin
          adr_byte = sh;
          rd = sh[0];
          act = (sh[7:1] == my_addr);
        end
        else if (!rd)
          wr_last = sh;
        sda_oen = !(act && !(rd && !aph));
      end
      else
      begin
        if (bitn == 9)
        begin
          if (!aph)
            idx = idx + 8'h01;
          bitn = 0;
          aph = 1'b0;
        end
        dat = rd_base + idx;
        sda_oen = !rd || dat[7 - bitn];
      end
    end
endmodule : twmr_target_model
`default_nettype wire
